//--- include/rmc_pkg.sv
// Constants, field layouts and state codes of the recording controller.
// Assumes a 100 MHz system clock and a word-addressed register port.
package rmc_pkg;
	localparam int NTRIG = 6;
	localparam int NSCHED = 10;
	localparam int NCH = 6;
	localparam int SW = 24;
	localparam int NPOLE = 5;
	localparam int DC_SH = 10;
	localparam int CLK_HZ = 100_000_000;
	localparam int TICK_S = 1;
	localparam int SEC_CYC = TICK_S * CLK_HZ;
	// Register word addresses
	localparam logic [7:0] A_MODE = 8'h00;
	localparam logic [7:0] A_CMD = 8'h01;
	localparam logic [7:0] A_STAT = 8'h02;
	localparam logic [7:0] A_TIME = 8'h03;
	localparam logic [7:0] A_WARM = 8'h04;
	localparam logic [7:0] A_EVCF = 8'h05;
	localparam logic [7:0] A_MAXD = 8'h06;
	localparam logic [7:0] A_PRPO = 8'h07;
	localparam logic [7:0] A_TRIG = 8'h20;
	localparam logic [7:0] A_SCHED = 8'h40;
	localparam int T_STRIDE = 4;
	localparam int S_STRIDE = 8;
	// Fields
	localparam int CMD_START = 0;
	localparam int CMD_STOP = 1;
	localparam int EV_WIN = 0;
	localparam int EV_ON = 8;
	localparam int EV_OFF = 12;
	localparam int PP_PRE = 0;
	localparam int PP_POST = 16;
	localparam int TC_EN = 0;
	localparam int TC_RATIO = 1;
	localparam int TC_CH = 2;
	localparam int TC_HP = 5;
	localparam int TC_LP = 8;
	localparam int TC_FSH = 11;
	localparam int TC_STA = 15;
	localparam int TC_LTA = 19;
	localparam int SC_EN = 0;
	localparam int SC_CONT = 1;
	// Reset values
	localparam logic [31:0] RST_WARM = 32'h0000_012c;
	localparam logic [31:0] RST_EVCF = 32'h0000_1201;
	localparam logic [31:0] RST_MAXD = 32'h0000_0258;
	localparam logic [31:0] RST_PRPO = 32'h000a_0005;
	typedef enum logic [1:0] {
		RMC_CONT = 2'h0,
		RMC_EVENT = 2'h1,
		RMC_SCHED = 2'h2
	} rmc_mode_t;
	typedef enum logic [3:0] {
		PW_ON = 4'h1,
		PW_PREP = 4'h2,
		PW_CHECK = 4'h4,
		PW_SLEEP = 4'h8
	} rmc_pw_t;
	// Log codes: trigger on 0..5, trigger off 6..11, event on 12, event off 13
	localparam int NLOG = 2 * NTRIG + 2;
endpackage : rmc_pkg

//--- include/rmc_trig_if.sv
// Signals between the controller and one trigger channel.
// Assumes a single clock shared by both ends.
`timescale 1ns/100ps
interface rmc_trig_if;
	logic smp_v;
	logic signed [rmc_pkg::SW-1:0] smp;
	logic [31:0] cfg;
	logic [31:0] level;
	logic [31:0] hold;
	logic on;
	modport ctl (output smp_v, smp, cfg, level, hold, input on);
	modport trg (input smp_v, smp, cfg, level, hold, output on);
endinterface : rmc_trig_if

//--- core/rmc_trig.sv
// One trigger: offset removal, pole chain, threshold or average ratio.
// Assumes samples arrive as one-cycle strobes on the system clock.
`timescale 1ns/100ps
module rmc_trig (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// Controller side
	rmc_trig_if.trg t
);
	logic signed [31:0] x, dc_q, stg_q [rmc_pkg::NPOLE], stg_in [rmc_pkg::NPOLE], y;
	logic [31:0] mag, sta_q, lta_q, hcnt_q;
	logic [2:0] hp, lp;
	logic [3:0] fsh, ssh, lsh;
	logic [39:0] lim;
	assign x = 32'(t.smp);
	assign hp = t.cfg[rmc_pkg::TC_HP +: 3];
	assign lp = t.cfg[rmc_pkg::TC_LP +: 3];
	assign fsh = t.cfg[rmc_pkg::TC_FSH +: 4];
	assign ssh = t.cfg[rmc_pkg::TC_STA +: 4];
	assign lsh = t.cfg[rmc_pkg::TC_LTA +: 4];
	assign lim = 40'(lta_q) * 40'(t.level[7:0]);
	// One averaging step, shift applied to the difference only
	function automatic logic [31:0] avg_step(input logic [31:0] a, input logic [31:0] m,
		input logic [3:0] sh);
		logic signed [32:0] df;
		df = $signed({1'b0, m}) - $signed({1'b0, a});
		return 32'($signed({1'b0, a}) + (df >>> sh));
	endfunction : avg_step
	// Pole chain, high poles first then low poles, at most five
	always_comb begin
		logic signed [31:0] v;
		v = x - dc_q;
		for (int k = 0; k < rmc_pkg::NPOLE; k++) begin
			stg_in[k] = v;
			if (k < 32'(hp))
				v = v - stg_q[k];
			else if (k < 32'(hp) + 32'(lp))
				v = stg_q[k];
		end
		y = v;
		mag = y[31] ? 32'(-y) : 32'(y);
	end
	// Filter state
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			dc_q <= '0;
			for (int k = 0; k < rmc_pkg::NPOLE; k++)
				stg_q[k] <= '0;
		end else if (t.smp_v) begin
			dc_q <= dc_q + ((x - dc_q) >>> rmc_pkg::DC_SH);
			for (int k = 0; k < rmc_pkg::NPOLE; k++)
				stg_q[k] <= stg_q[k] + ((stg_in[k] - stg_q[k]) >>> fsh);
		end
	end
	// Short and long averages
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			sta_q <= '0;
			lta_q <= '0;
		end else if (t.smp_v) begin
			sta_q <= avg_step(sta_q, mag, ssh);
			lta_q <= avg_step(lta_q, mag, lsh);
		end
	end
	// On and off decision
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			t.on <= 1'b0;
			hcnt_q <= '0;
		end else if (!t.cfg[rmc_pkg::TC_EN]) begin
			t.on <= 1'b0;
			hcnt_q <= '0;
		end else if (t.smp_v) begin
			if (t.cfg[rmc_pkg::TC_RATIO]) begin
				if (40'(sta_q) > lim)
					t.on <= 1'b1;
				else if (sta_q <= lta_q)
					t.on <= 1'b0;
			end else if (mag > t.level) begin
				t.on <= 1'b1;
				hcnt_q <= '0;
			end else if (t.on) begin
				hcnt_q <= hcnt_q + 32'h1;
				if (hcnt_q + 32'h1 >= t.hold)
					t.on <= 1'b0;
			end
		end
	end
endmodule : rmc_trig

//--- core/rmc_ctl.sv
// Recording controller: modes, schedules, start and stop, events, power.
// Assumes same-clock sample strobes and a word-addressed register port.
`timescale 1ns/100ps
// Function
// - Continuous, event or scheduled global recording
// - Scheduled start needs one to ten schedules
// - Schedule window from start, duration, interval, count
// - Each schedule chooses continuous or event recording
// - Continuous overlap wins over event overlap
// - Offload, recheck gap, then sleep or stay
// - Continuous start records at once
// - Stop halts recording at once
// - Event start arms; running event records now
// - Scheduled start records at once inside window
// - Scheduled stop disables schedules until restart
// - Triggers per channel; coincidence declares event
// - Trigger and event messages go to log
// - Event start and end gate ring writes
// - Six triggers, own filter, level, type, channel
// - Real-time on and off decisions per trigger
// - Threshold trigger on above absolute level
// - Threshold off after hold time below level
// - Ratio trigger on above configured level
// - Ratio trigger off when ratio reaches one
// - Highpass, lowpass or bandpass, five poles max
// - Offset removal before every trigger filter
// - Event ends below triggers-off count
// - Event forced off after maximum duration
// - Pre-event and post-event seconds recorded
module rmc_ctl #(
	parameter int SEC_CYC = rmc_pkg::SEC_CYC
) (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// Register port
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	// Samples
	input wire logic smp_valid_in,
	input wire logic [rmc_pkg::NCH*rmc_pkg::SW-1:0] smp_data_in,
	// Ring buffer and log
	output logic ring_wr_en_out,
	output logic ring_cont_out,
	output logic [15:0] pre_secs_out,
	output logic soh_valid_out,
	output logic [7:0] soh_code_out,
	// Processor power
	input wire logic offload_done_in,
	output logic proc_on_out,
	output logic offload_req_out,
	output logic low_power_out
);
	localparam int NT = rmc_pkg::NTRIG;
	localparam int NS = rmc_pkg::NSCHED;
	localparam int NL = rmc_pkg::NLOG;

	function automatic logic [3:0] popc(input logic [NT-1:0] v);
		logic [3:0] n;
		n = '0;
		for (int i = 0; i < NT; i++)
			n = n + 4'(v[i]);
		return n;
	endfunction : popc

	function automatic logic in_blk(input logic [7:0] a, input logic [7:0] b, input int len);
		return (a >= b) && (32'(a) < 32'(b) + len);
	endfunction : in_blk

	////////////////////////////////////////////////////////////////////////
	// Registers
	rmc_pkg::rmc_mode_t mode_q;
	logic [31:0] now_q, warm_q, evcf_q, maxd_q, prpo_q;
	logic [31:0] tcfg_q [NT], tlev_q [NT], thold_q [NT];
	logic [31:0] s_start_q [NS], s_dur_q [NS], s_iv_q [NS], s_cnt_q [NS];
	logic [1:0] s_ctl_q [NS];
	logic [7:0] toff, soff;
	logic [2:0] ti;
	logic [3:0] si;
	logic wr_t, wr_s, start_cmd, stop_cmd, any_en, start_ok;
	assign toff = reg_addr_in - rmc_pkg::A_TRIG;
	assign soff = reg_addr_in - rmc_pkg::A_SCHED;
	assign ti = 3'(toff >> 2);
	assign si = 4'(soff >> 3);
	assign wr_t = reg_wr_in && in_blk(reg_addr_in, rmc_pkg::A_TRIG, NT * rmc_pkg::T_STRIDE);
	assign wr_s = reg_wr_in && in_blk(reg_addr_in, rmc_pkg::A_SCHED, NS * rmc_pkg::S_STRIDE);
	assign start_cmd = reg_wr_in && reg_addr_in == rmc_pkg::A_CMD && reg_wdata_in[rmc_pkg::CMD_START];
	assign stop_cmd = reg_wr_in && reg_addr_in == rmc_pkg::A_CMD && reg_wdata_in[rmc_pkg::CMD_STOP];
	always_comb begin
		any_en = 1'b0;
		for (int s = 0; s < NS; s++)
			any_en = any_en | s_ctl_q[s][rmc_pkg::SC_EN];
	end
	assign start_ok = start_cmd && !stop_cmd && (mode_q != rmc_pkg::RMC_SCHED || any_en);

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			mode_q <= rmc_pkg::RMC_CONT;
			warm_q <= rmc_pkg::RST_WARM;
			evcf_q <= rmc_pkg::RST_EVCF;
			maxd_q <= rmc_pkg::RST_MAXD;
			prpo_q <= rmc_pkg::RST_PRPO;
		end else if (reg_wr_in) begin
			case (reg_addr_in)
				rmc_pkg::A_MODE: mode_q <= rmc_pkg::rmc_mode_t'(reg_wdata_in[1:0]);
				rmc_pkg::A_WARM: warm_q <= reg_wdata_in;
				rmc_pkg::A_EVCF: evcf_q <= reg_wdata_in;
				rmc_pkg::A_MAXD: maxd_q <= reg_wdata_in;
				rmc_pkg::A_PRPO: prpo_q <= reg_wdata_in;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			for (int i = 0; i < NT; i++) begin
				tcfg_q[i] <= '0;
				tlev_q[i] <= '0;
				thold_q[i] <= '0;
			end
		end else if (wr_t) begin
			case (toff[1:0])
				2'h0: tcfg_q[ti] <= reg_wdata_in;
				2'h1: tlev_q[ti] <= reg_wdata_in;
				2'h2: thold_q[ti] <= reg_wdata_in;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			for (int s = 0; s < NS; s++) begin
				s_start_q[s] <= '0;
				s_dur_q[s] <= '0;
				s_iv_q[s] <= '0;
				s_cnt_q[s] <= '0;
				s_ctl_q[s] <= '0;
			end
		end else if (wr_s) begin
			case (soff[2:0])
				3'h0: s_start_q[si] <= reg_wdata_in;
				3'h1: s_dur_q[si] <= reg_wdata_in;
				3'h2: s_iv_q[si] <= reg_wdata_in;
				3'h3: s_cnt_q[si] <= reg_wdata_in;
				3'h4: s_ctl_q[si] <= reg_wdata_in[1:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Seconds base and run state
	logic [31:0] div_q;
	logic tick_q, run_q, err_q;
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			div_q <= '0;
			tick_q <= 1'b0;
			now_q <= '0;
		end else begin
			tick_q <= div_q == 32'(SEC_CYC - 1);
			div_q <= (div_q == 32'(SEC_CYC - 1)) ? '0 : div_q + 32'h1;
			if (reg_wr_in && reg_addr_in == rmc_pkg::A_TIME)
				now_q <= reg_wdata_in;
			else if (tick_q)
				now_q <= now_q + 32'h1;
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			run_q <= 1'b0;
			err_q <= 1'b0;
		end else if (stop_cmd) begin
			run_q <= 1'b0;
		end else if (start_cmd) begin
			run_q <= start_ok;
			err_q <= !start_ok;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Schedule windows
	logic [31:0] nxt_q [NS], end_q [NS], left_q [NS];
	logic [NS-1:0] open_q;
	logic sched_on;
	assign sched_on = run_q && mode_q == rmc_pkg::RMC_SCHED;
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			open_q <= '0;
			for (int s = 0; s < NS; s++) begin
				nxt_q[s] <= '0;
				end_q[s] <= '0;
				left_q[s] <= '0;
			end
		end else begin
			for (int s = 0; s < NS; s++) begin
				if (start_ok) begin
					open_q[s] <= 1'b0;
					nxt_q[s] <= s_start_q[s];
					left_q[s] <= s_ctl_q[s][rmc_pkg::SC_EN] ? s_cnt_q[s] : '0;
				end else if (!sched_on) begin
					open_q[s] <= 1'b0;
				end else if (open_q[s]) begin
					if (now_q >= end_q[s])
						open_q[s] <= 1'b0;
				end else if (left_q[s] != '0 && now_q >= nxt_q[s]) begin
					open_q[s] <= now_q < nxt_q[s] + s_dur_q[s];
					end_q[s] <= nxt_q[s] + s_dur_q[s];
					nxt_q[s] <= nxt_q[s] + s_iv_q[s];
					left_q[s] <= left_q[s] - 32'h1;
				end
			end
		end
	end

	logic any_cont, any_ev, any_open, pend;
	logic [31:0] gap;
	always_comb begin
		any_cont = 1'b0;
		any_ev = 1'b0;
		pend = 1'b0;
		gap = '1;
		for (int s = 0; s < NS; s++) begin
			if (open_q[s] && s_ctl_q[s][rmc_pkg::SC_CONT])
				any_cont = 1'b1;
			if (open_q[s] && !s_ctl_q[s][rmc_pkg::SC_CONT])
				any_ev = 1'b1;
			if (left_q[s] != '0) begin
				pend = 1'b1;
				if (now_q >= nxt_q[s])
					gap = '0;
				else if (nxt_q[s] - now_q < gap)
					gap = nxt_q[s] - now_q;
			end
		end
		any_open = any_cont | any_ev;
	end

	////////////////////////////////////////////////////////////////////////
	// Triggers
	logic [NT-1:0] ton, ton_q;
	generate
		for (genvar g = 0; g < NT; g++) begin : g_trig
			rmc_trig_if tif ();
			logic [2:0] ch;
			assign ch = tcfg_q[g][rmc_pkg::TC_CH +: 3];
			assign tif.smp_v = smp_valid_in;
			assign tif.smp = smp_data_in[32'(ch) * rmc_pkg::SW +: rmc_pkg::SW];
			assign tif.cfg = (32'(ch) < rmc_pkg::NCH) ? tcfg_q[g] : '0;
			assign tif.level = tlev_q[g];
			assign tif.hold = thold_q[g];
			assign ton[g] = tif.on;
			rmc_trig u_trig (
				.clk_sys_in(clk_sys_in),
				.rst_in(rst_in),
				.t(tif.trg)
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Coincidence and events
	logic [7:0] age_q [NT];
	logic [NT-1:0] recent;
	logic [31:0] edur_q;
	logic [15:0] post_q;
	logic ev_q, ev_gate, ev_set, ev_clr;
	always_comb begin
		for (int i = 0; i < NT; i++)
			recent[i] = ton[i] && age_q[i] < evcf_q[rmc_pkg::EV_WIN +: 8];
	end
	assign ev_set = !ev_q && popc(recent) >= evcf_q[rmc_pkg::EV_ON +: 4];
	assign ev_clr = ev_q && (popc(ton) < evcf_q[rmc_pkg::EV_OFF +: 4]
		|| edur_q >= maxd_q);
	assign ev_gate = ev_q || post_q != '0;

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			ton_q <= '0;
			for (int i = 0; i < NT; i++)
				age_q[i] <= '0;
		end else begin
			ton_q <= ton;
			for (int i = 0; i < NT; i++) begin
				if (ton[i] && !ton_q[i])
					age_q[i] <= '0;
				else if (tick_q && age_q[i] != 8'hff)
					age_q[i] <= age_q[i] + 8'h1;
			end
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			ev_q <= 1'b0;
			edur_q <= '0;
			post_q <= '0;
		end else begin
			if (ev_set) begin
				ev_q <= 1'b1;
				edur_q <= '0;
			end else if (ev_clr) begin
				ev_q <= 1'b0;
				post_q <= prpo_q[rmc_pkg::PP_POST +: 16];
			end else begin
				if (ev_q && tick_q)
					edur_q <= edur_q + 32'h1;
				if (!ev_q && tick_q && post_q != '0)
					post_q <= post_q - 16'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Log messages, one per cycle, set wins over clear
	logic [NL-1:0] lset, lpend_q, lclr;
	logic [7:0] lcode;
	always_comb begin
		lset = {ev_clr, ev_set, ton_q & ~ton, ton & ~ton_q};
		lclr = '0;
		lcode = '0;
		for (int i = NL - 1; i >= 0; i--) begin
			if (lpend_q[i]) begin
				lclr = '0;
				lclr[i] = 1'b1;
				lcode = 8'(i);
			end
		end
	end
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			lpend_q <= '0;
			soh_valid_out <= 1'b0;
			soh_code_out <= '0;
		end else begin
			lpend_q <= (lpend_q & ~lclr) | lset;
			soh_valid_out <= lpend_q != '0;
			soh_code_out <= lcode;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Ring write gate
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			ring_wr_en_out <= 1'b0;
			ring_cont_out <= 1'b0;
			pre_secs_out <= '0;
		end else begin
			pre_secs_out <= prpo_q[rmc_pkg::PP_PRE +: 16];
			case (mode_q)
				rmc_pkg::RMC_CONT: begin
					ring_wr_en_out <= run_q;
					ring_cont_out <= 1'b1;
				end
				rmc_pkg::RMC_EVENT: begin
					ring_wr_en_out <= run_q && ev_gate;
					ring_cont_out <= 1'b0;
				end
				rmc_pkg::RMC_SCHED: begin
					ring_wr_en_out <= sched_on && (any_cont || (any_ev && ev_gate));
					ring_cont_out <= any_cont;
				end
				default: begin
					ring_wr_en_out <= 1'b0;
					ring_cont_out <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Low power sequence
	rmc_pkg::rmc_pw_t pw_q;
	logic done_s1_q, done_s2_q, idle, far;
	assign idle = sched_on && !any_open;
	assign far = pend ? gap > warm_q : 1'b0;
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			done_s1_q <= 1'b0;
			done_s2_q <= 1'b0;
		end else begin
			done_s1_q <= offload_done_in;
			done_s2_q <= done_s1_q;
		end
	end
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			pw_q <= rmc_pkg::PW_ON;
			proc_on_out <= 1'b1;
			offload_req_out <= 1'b0;
			low_power_out <= 1'b0;
		end else begin
			case (pw_q)
				rmc_pkg::PW_ON: if (idle && far) begin
					pw_q <= rmc_pkg::PW_PREP;
					offload_req_out <= 1'b1;
				end
				rmc_pkg::PW_PREP: if (done_s2_q) begin
					pw_q <= rmc_pkg::PW_CHECK;
					offload_req_out <= 1'b0;
					proc_on_out <= 1'b0;
				end
				rmc_pkg::PW_CHECK: if (idle && far) begin
					pw_q <= rmc_pkg::PW_SLEEP;
					low_power_out <= 1'b1;
				end else begin
					pw_q <= rmc_pkg::PW_ON;
					proc_on_out <= 1'b1;
				end
				rmc_pkg::PW_SLEEP: if (!(idle && far)) begin
					pw_q <= rmc_pkg::PW_ON;
					low_power_out <= 1'b0;
					proc_on_out <= 1'b1;
				end
				default: begin
					pw_q <= rmc_pkg::PW_ON;
					proc_on_out <= 1'b1;
					offload_req_out <= 1'b0;
					low_power_out <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read port
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			reg_rdata_out <= '0;
		end else if (!reg_rd_in) begin
			reg_rdata_out <= '0;
		end else if (in_blk(reg_addr_in, rmc_pkg::A_TRIG, NT * rmc_pkg::T_STRIDE)) begin
			case (toff[1:0])
				2'h0: reg_rdata_out <= tcfg_q[ti];
				2'h1: reg_rdata_out <= tlev_q[ti];
				2'h2: reg_rdata_out <= thold_q[ti];
				default: reg_rdata_out <= '0;
			endcase
		end else if (in_blk(reg_addr_in, rmc_pkg::A_SCHED, NS * rmc_pkg::S_STRIDE)) begin
			case (soff[2:0])
				3'h0: reg_rdata_out <= s_start_q[si];
				3'h1: reg_rdata_out <= s_dur_q[si];
				3'h2: reg_rdata_out <= s_iv_q[si];
				3'h3: reg_rdata_out <= s_cnt_q[si];
				3'h4: reg_rdata_out <= {30'h0, s_ctl_q[si]};
				3'h5: reg_rdata_out <= {31'h0, open_q[si]};
				default: reg_rdata_out <= '0;
			endcase
		end else begin
			case (reg_addr_in)
				rmc_pkg::A_MODE: reg_rdata_out <= {30'h0, mode_q};
				rmc_pkg::A_STAT: reg_rdata_out <= {16'h0, pw_q, err_q, ev_q,
					ring_wr_en_out, run_q, 2'h0, ton};
				rmc_pkg::A_TIME: reg_rdata_out <= now_q;
				rmc_pkg::A_WARM: reg_rdata_out <= warm_q;
				rmc_pkg::A_EVCF: reg_rdata_out <= evcf_q;
				rmc_pkg::A_MAXD: reg_rdata_out <= maxd_q;
				rmc_pkg::A_PRPO: reg_rdata_out <= prpo_q;
				default: reg_rdata_out <= '0;
			endcase
		end
	end
endmodule : rmc_ctl

//--- bench/rmc_sva.sv
// Port checker of the recording controller.
// Assumes one clock and a bind onto rmc_ctl.
`timescale 1ns/100ps
module rmc_sva (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// Register port
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [31:0] reg_rdata_out,
	// Outputs
	input wire logic ring_wr_en_out,
	input wire logic soh_valid_out,
	input wire logic [7:0] soh_code_out,
	input wire logic proc_on_out,
	input wire logic offload_req_out,
	input wire logic low_power_out
);
	default clocking @(posedge clk_sys_in);
	endclocking
	default disable iff (rst_in);
	logic [1:0] mode_q;
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in)
			mode_q <= 2'h0;
		else if (reg_wr_in && reg_addr_in == rmc_pkg::A_MODE)
			mode_q <= reg_wdata_in[1:0];
	end
	sequence s_cmd;
		reg_wr_in && reg_addr_in == rmc_pkg::A_CMD;
	endsequence
	sequence s_stop;
		s_cmd ##0 reg_wdata_in[1];
	endsequence
	rd_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
		else $error("read data not zero");
	mode_echo_a: assert property (reg_rd_in && reg_addr_in == rmc_pkg::A_MODE |=>
		reg_rdata_out[1:0] == mode_q) else $error("mode readback wrong");
	cont_start_a: assert property (s_cmd ##0 (reg_wdata_in[1:0] == 2'h1 && mode_q == 2'h0)
		|-> ##[1:3] ring_wr_en_out) else $error("start did not record");
	stop_halt_a: assert property (s_stop |-> ##2 !ring_wr_en_out)
		else $error("stop did not halt");
	stop_wake_a: assert property (s_stop |-> ##[1:4] !low_power_out)
		else $error("stop left low power");
	sleep_off_a: assert property ($rose(low_power_out) |-> !proc_on_out)
		else $error("processor on in low power");
	offload_on_a: assert property ($rose(offload_req_out) |-> proc_on_out)
		else $error("offload with processor off");
	soh_code_a: assert property (soh_valid_out |-> soh_code_out < 8'h0e)
		else $error("bad log code");
endmodule : rmc_sva
bind rmc_ctl rmc_sva u_rmc_sva (.clk_sys_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
	.reg_rd_in, .reg_rdata_out, .ring_wr_en_out, .soh_valid_out, .soh_code_out, .proc_on_out,
	.offload_req_out, .low_power_out);

//--- bench/rmc_far.sv
// Far side model: sensor channels and storage offload.
// Assumes one clock; a sample every fourth cycle.
`timescale 1ns/100ps
module rmc_far (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// Bench control
	input wire logic signed [23:0] amp_in,
	// Block side
	input wire logic offload_req_in,
	output logic smp_valid_out,
	output logic [rmc_pkg::NCH*rmc_pkg::SW-1:0] smp_data_out,
	output logic offload_done_out
);
	int seed = 17;
	logic [1:0] ph_q;
	logic [1:0] dly_q;
	logic sgn_q;
	always @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			ph_q <= 2'h0;
			dly_q <= 2'h0;
			sgn_q <= 1'b0;
			smp_valid_out <= 1'b0;
			smp_data_out <= '0;
			offload_done_out <= 1'b0;
		end else begin
			ph_q <= ph_q + 2'h1;
			smp_valid_out <= ph_q == 2'h3;
			// Alternating sign plus noise, junk between samples
			for (int c = 0; c < rmc_pkg::NCH; c++)
				smp_data_out[c*rmc_pkg::SW +: rmc_pkg::SW] <= ph_q != 2'h3 ? 24'($random(seed)) :
					(sgn_q ? amp_in : -amp_in) + 24'($random(seed) % 8);
			sgn_q <= sgn_q ^ (ph_q == 2'h3);
			// Offload ends a few cycles after request
			dly_q <= offload_req_in ? dly_q + 2'(dly_q != 2'h3) : 2'h0;
			offload_done_out <= dly_q == 2'h3;
		end
	end
endmodule : rmc_far

//--- bench/tb_top.sv
// Bench of the recording controller with the far side model.
// Assumes one second of SC cycles at 100 MHz.
`timescale 1ns/100ps
module tb_top;
	localparam int SC = 10;
	logic clk_sys_in = 1'b0;
	logic rst_in = 1'b1;
	logic [7:0] addr = 8'h0;
	logic [31:0] wd = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic ofs = 1'b0;
	logic signed [23:0] amp = 24'sh0;
	logic [31:0] rdat, d;
	logic [rmc_pkg::NCH*rmc_pkg::SW-1:0] sd;
	logic [15:0] pre;
	logic [7:0] shc;
	logic sv, ring, cont, shv, done, pon, oreq, lp, pr;
	logic [7:0] ra[5] = '{rmc_pkg::A_WARM, rmc_pkg::A_EVCF, rmc_pkg::A_MAXD, rmc_pkg::A_PRPO, 8'h10};
	logic [31:0] rv[5] = '{rmc_pkg::RST_WARM, rmc_pkg::RST_EVCF, rmc_pkg::RST_MAXD,
		rmc_pkg::RST_PRPO, 32'h0};
	logic [31:0] sc[10] = '{3, 2, 4, 2, 3, 3, 1, 100, 1, 1};
	logic [7:0] lg[$];
	int error_cnt = 0;
	int total_checks = 0;
	int cyc = 0;
	int nwin, bad;
	rmc_ctl #(.SEC_CYC(SC)) u_rmc_ctl (.clk_sys_in, .rst_in, .reg_addr_in(addr),
		.reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat),
		.smp_valid_in(sv), .smp_data_in(sd), .ring_wr_en_out(ring), .ring_cont_out(cont),
		.pre_secs_out(pre), .soh_valid_out(shv), .soh_code_out(shc), .offload_done_in(done),
		.proc_on_out(pon), .offload_req_out(oreq), .low_power_out(lp));
	rmc_far u_rmc_far (.clk_sys_in, .rst_in, .amp_in(amp), .offload_req_in(oreq),
		.smp_valid_out(sv), .smp_data_out(sd), .offload_done_out(done));
	////////////////////////////////////////
	function automatic logic [31:0] prpo(logic [15:0] pr_s, logic [15:0] po_s);
		return {po_s, pr_s};
	endfunction : prpo
	function automatic logic [31:0] tcfg(logic [2:0] ch);
		return (32'(ch) << 2) | 32'h1;
	endfunction : tcfg
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic w(logic [7:0] a, logic [31:0] v);
		@(posedge clk_sys_in);
		addr <= a;
		wd <= v;
		wr <= 1'b1;
		@(posedge clk_sys_in);
		wr <= 1'b0;
	endtask : w
	task automatic r(logic [7:0] a);
		@(posedge clk_sys_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys_in);
		rd <= 1'b0;
		#1;
		d = rdat;
	endtask : r
	task automatic cy(int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask : cy
	task automatic sa(logic signed [23:0] v);
		@(posedge clk_sys_in);
		amp <= v;
	endtask : sa
	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim
	////////////////////////////////////////
	initial forever #5 clk_sys_in = ~clk_sys_in;
	initial begin
		repeat (4) @(posedge clk_sys_in);
		rst_in <= 1'b0;
	end
	always @(posedge clk_sys_in) begin
		cyc <= cyc + 1;
		if (shv === 1'b1)
			lg.push_back(shc);
		if (oreq === 1'b1)
			ofs <= 1'b1;
		if (cyc == 5000) begin
			error_cnt++;
			end_sim();
		end
	end
	initial begin
		@(negedge rst_in);
		foreach (ra[i]) begin
			r(ra[i]);
			chk("reset reg", rv[i], d);
		end
		chk("pre secs", 32'h5, pre);
		w(rmc_pkg::A_CMD, 32'h1);
		cy(3);
		chk("cont ring", 32'h1, ring);
		w(rmc_pkg::A_CMD, 32'h3);
		cy(2);
		chk("stop ring", 32'h0, ring);
		$display("test continuous done");
		w(rmc_pkg::A_PRPO, prpo(16'h3, 16'h0));
		w(rmc_pkg::A_EVCF, 32'h1101);
		w(rmc_pkg::A_TRIG + 8'h1, 32'h10000);
		w(rmc_pkg::A_TRIG + 8'h2, 32'h8);
		w(rmc_pkg::A_TRIG, tcfg(3'h0));
		w(rmc_pkg::A_MODE, 32'h1);
		r(rmc_pkg::A_MODE);
		chk("mode", 32'h1, d);
		w(rmc_pkg::A_CMD, 32'h1);
		cy(20);
		chk("pre secs", 32'h3, pre);
		chk("idle ring", 32'h0, ring);
		lg.delete();
		sa(24'sh100000);
		cy(40);
		chk("trig on", 32'h0, lg[0]);
		chk("event on", 32'hc, lg[1]);
		chk("event ring", 32'h1, ring);
		sa(24'sh0);
		cy(20);
		r(rmc_pkg::A_STAT);
		chk("trig held", 32'h1, d[0]);
		cy(60);
		chk("trig off", 32'h6, lg[2]);
		chk("event off", 32'hd, lg[3]);
		chk("post ring", 32'h0, ring);
		w(rmc_pkg::A_CMD, 32'h2);
		sa(24'sh100000);
		cy(40);
		chk("stopped ring", 32'h0, ring);
		w(rmc_pkg::A_CMD, 32'h1);
		cy(3);
		chk("armed ring", 32'h1, ring);
		w(rmc_pkg::A_MAXD, 32'h1);
		cy(30);
		chk("max dur ring", 32'h0, ring);
		sa(24'sh0);
		$display("test event done");
		w(rmc_pkg::A_CMD, 32'h2);
		w(rmc_pkg::A_MODE, 32'h2);
		w(rmc_pkg::A_CMD, 32'h1);
		r(rmc_pkg::A_STAT);
		chk("start err", 32'h1, d[11]);
		chk("run", 32'h0, d[8]);
		foreach (sc[i])
			w(rmc_pkg::A_SCHED + 8'(i / 5 * 8 + i % 5), sc[i]);
		w(rmc_pkg::A_TIME, 32'h0);
		w(rmc_pkg::A_CMD, 32'h1);
		nwin = 0;
		bad = 0;
		pr = 1'b0;
		repeat (150) begin
			@(negedge clk_sys_in);
			nwin += ring && !pr;
			bad += ring && !cont;
			pr = ring;
		end
		chk("windows", 32'h2, nwin);
		chk("cont overlap", 32'h0, bad);
		w(rmc_pkg::A_TIME, 32'h3);
		w(rmc_pkg::A_CMD, 32'h1);
		cy(5);
		chk("start in window", 32'h1, ring);
		w(rmc_pkg::A_CMD, 32'h2);
		cy(40);
		chk("sched stop", 32'h0, ring);
		$display("test schedule done");
		w(rmc_pkg::A_WARM, 32'h2);
		w(rmc_pkg::A_SCHED, 32'hc8);
		w(rmc_pkg::A_CMD, 32'h1);
		for (int i = 0; i < 300 && lp !== 1'b1; i++)
			@(posedge clk_sys_in);
		#1;
		chk("offload seen", 32'h1, ofs);
		chk("low power", 32'h1, lp);
		chk("proc off", 32'h0, pon);
		w(rmc_pkg::A_CMD, 32'h2);
		cy(5);
		chk("wake on stop", 32'h0, lp);
		$display("test power done");
		end_sim();
	end
endmodule : tb_top
